// ---- hw/usbec_top.sv ----
// AHB-Lite register block: received byte counts, endpoint FIFO resets, interrupt summary
//
// Overview of operation
// - Low count register shows count bits seven to zero of selected endpoint.
// - Count equals data bytes received after the data PID of last packet.
// - High count register bits two to zero carry count bits ten to eight.
// - High count bits seven to three read zero; firmware writes no ones there.
// - Both count registers follow the endpoint chosen by the select register.
// - FIFO reset register holds one bit per endpoint, bits zero to six.
// - FIFO reset bit seven is reserved, reads zero; firmware never sets it.
// - Interrupt summary register has its own address and ignores writes.
// - Summary bit follows whether any interrupt source of that endpoint pends.
`timescale 1ns/10ps
module usbec_top
  import usbec_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic [SELECTED_ENDPOINT_NUMBER_W-1:0]     rx_ep,
  input  wire logic                   rx_pkt_start,
  input  wire logic                   rx_byte_valid,
  input  wire logic                   rx_pkt_end,
  input  wire logic                   usb_bus_reset,
  input  wire logic                   fifo_rd,
  input  wire logic [usbec_pkg::NUM_EP-1:0] ep_src_pending,
  output logic [usbec_pkg::NUM_EP-1:0] ep_fifo_reset,
  output logic [usbec_pkg::NUM_EP-1:0] ep_accept,
  output logic                        irq
);
  import usbec_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0]  addr_q;
  logic               wr_pend_q;
  logic               rd_wait_q;
  logic [31:0]        hrdata_q;
  logic [SELECTED_ENDPOINT_NUMBER_W-1:0] sel_q;
  logic [NUM_EP-1:0]  fifo_rst_q;
  logic [NUM_EP-1:0]  summary_q;

  logic               addr_phase;
  logic               sel_write;
  logic               rst_write;
  logic               stat_write;
  logic               mask_write;
  logic               sel_valid;
  logic [COUNT_W-1:0] sel_count;
  logic [31:0]        rd_value;
  logic [7:0]         wbyte;

  logic [NUM_EP-1:0]  ep_match;
  logic [NUM_EP-1:0]  ep_done;
  logic [NUM_EP-1:0]  ep_rd;
  logic [COUNT_W-1:0] ep_count [NUM_EP];

  usbec_irq_if irq_bus ();

  // ---------------------------------------------------------------
  // AHB-Lite address phase and write decode
  // ---------------------------------------------------------------

  // A transfer is taken only when selected, active and the bus is ready
  assign addr_phase = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;

  // Writes land in the data phase that follows the address phase
  assign wbyte      = hwdata[7:0];
  assign sel_write  = wr_pend_q & (addr_q == ADDR_ENDPOINT_SELECT);
  assign rst_write  = wr_pend_q & (addr_q == ADDR_ENDPOINT_FIFO_RESET);
  assign stat_write = wr_pend_q & (addr_q == ADDR_IRQ_STATUS);
  assign mask_write = wr_pend_q & (addr_q == ADDR_IRQ_MASK);

  // Reads take one wait state so a read right after a write sees new data
  assign hreadyout = ~rd_wait_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Address capture and pending-phase flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q    <= '0;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end
    else
    begin
      if (addr_phase)
        addr_q <= haddr[ADDR_W-1:0];
      wr_pend_q <= addr_phase & hwrite;
      rd_wait_q <= addr_phase & ~hwrite;
    end
  end

  // ---------------------------------------------------------------
  // Software-written control registers
  // ---------------------------------------------------------------

  // Endpoint select steers both count registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_q <= RST_ENDPOINT_SELECT;
    else if (sel_write)
      sel_q <= wbyte[SELECTED_ENDPOINT_NUMBER_W-1:0];
  end

  // FIFO reset bits; bit seven is never stored so it always reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fifo_rst_q <= RST_ENDPOINT_FIFO_RESET;
    else if (rst_write)
      fifo_rst_q <= wbyte[NUM_EP-1:0];
  end

  assign ep_fifo_reset = fifo_rst_q;

  // ---------------------------------------------------------------
  // Endpoint summary, tracks the pending sources of each endpoint
  // ---------------------------------------------------------------

  // Registered so firmware reads a clean value; writes have no path here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      summary_q <= '0;
    else
      summary_q <= ep_src_pending;
  end

  // ---------------------------------------------------------------
  // Per-endpoint counters
  // ---------------------------------------------------------------

  // Incoming traffic goes only to the endpoint it addresses
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_ep
      assign ep_match[g] = (rx_ep == SELECTED_ENDPOINT_NUMBER_W'(g));
      assign ep_rd[g]    = fifo_rd & (sel_q == SELECTED_ENDPOINT_NUMBER_W'(g));

      usbec_ep_count u_ep (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .fifo_rst   (fifo_rst_q[g]),
        .bus_rst    (usb_bus_reset),
        .pkt_start  (rx_pkt_start & ep_match[g]),
        .byte_valid (rx_byte_valid & ep_match[g]),
        .pkt_end    (rx_pkt_end & ep_match[g]),
        .rd_byte    (ep_rd[g]),
        .accept     (ep_accept[g]),
        .pkt_done   (ep_done[g]),
        .last_count (ep_count[g]),
        .wr_ptr     (),
        .rd_ptr     ()
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Count selection for the two count registers
  // ---------------------------------------------------------------

  // Select value seven names no endpoint, so the counts read zero
  assign sel_valid = (sel_q < SELECTED_ENDPOINT_NUMBER_W'(NUM_EP));
  assign sel_count = sel_valid ? ep_count[sel_q] : RST_COUNT;

  // ---------------------------------------------------------------
  // Interrupt collection
  // ---------------------------------------------------------------

  // Packet-done events per endpoint plus a bus reset event
  assign irq_bus.evt        = {usb_bus_reset, ep_done};
  assign irq_bus.w1c        = stat_write ? wbyte : RST_IRQ;
  assign irq_bus.mask_we    = mask_write;
  assign irq_bus.mask_wdata = wbyte;
  assign irq                = irq_bus.irq;

  usbec_irq u_irq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (irq_bus.col)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------

  // Unmapped addresses read zero; narrow registers sit in the low bits
  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (addr_q)
      ADDR_ENDPOINT_SELECT:
        rd_value[SELECTED_ENDPOINT_NUMBER_W-1:0] = sel_q;
      ADDR_ENDPOINT_FIFO_RESET:
        rd_value[NUM_EP-1:0] = fifo_rst_q;
      ADDR_RX_COUNT_LOW:
        rd_value[COUNT_LO_W-1:0] = sel_count[COUNT_LO_W-1:0];
      ADDR_RX_COUNT_HIGH:
        rd_value[COUNT_HI_W-1:0] = sel_count[COUNT_W-1:COUNT_LO_W];
      ADDR_ENDPOINT_IRQ_SUMMARY:
        rd_value[NUM_EP-1:0] = summary_q;
      ADDR_IRQ_STATUS:
        rd_value[IRQ_W-1:0] = irq_bus.status;
      ADDR_IRQ_MASK:
        rd_value[IRQ_W-1:0] = irq_bus.mask;
      default:
        rd_value = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (rd_wait_q)
      hrdata_q <= rd_value;
  end

  // hsize is accepted but unused: only whole-word transfers are issued
  logic unused_hsize;
  assign unused_hsize = |hsize;

endmodule

// ---- hw/usbec_pkg.sv ----
// Package of register map, field layout and reset values for the endpoint count block
package usbec_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned IDX_ENDPOINT_SELECT      = 'hC7;
  localparam int unsigned IDX_ENDPOINT_FIFO_RESET  = 'hD5;
  localparam int unsigned IDX_RX_COUNT_LOW         = 'hE2;
  localparam int unsigned IDX_RX_COUNT_HIGH        = 'hE3;
  localparam int unsigned IDX_ENDPOINT_IRQ_SUMMARY = 'hF8;
  localparam int unsigned IDX_IRQ_STATUS           = 'hF0;
  localparam int unsigned IDX_IRQ_MASK             = 'hF1;

  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_ENDPOINT_SELECT      = ADDR_W'(IDX_ENDPOINT_SELECT * 4);
  localparam logic [ADDR_W-1:0] ADDR_ENDPOINT_FIFO_RESET  = ADDR_W'(IDX_ENDPOINT_FIFO_RESET * 4);
  localparam logic [ADDR_W-1:0] ADDR_RX_COUNT_LOW         = ADDR_W'(IDX_RX_COUNT_LOW * 4);
  localparam logic [ADDR_W-1:0] ADDR_RX_COUNT_HIGH        = ADDR_W'(IDX_RX_COUNT_HIGH * 4);
  localparam logic [ADDR_W-1:0] ADDR_ENDPOINT_IRQ_SUMMARY = ADDR_W'(IDX_ENDPOINT_IRQ_SUMMARY * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS           = ADDR_W'(IDX_IRQ_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK             = ADDR_W'(IDX_IRQ_MASK * 4);

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_EP     = 7;
  localparam int unsigned SELECTED_ENDPOINT_NUMBER_W    = 3;
  localparam int unsigned COUNT_W    = 11;
  localparam int unsigned COUNT_LO_W = 8;
  localparam int unsigned COUNT_HI_W = 3;
  localparam int unsigned PTR_W      = 10;
  localparam int unsigned IRQ_W      = 8;
  localparam int unsigned IRQ_BUSRST_BIT = 7;

  // ---------------------------------------------------------------
  // Reset values and count saturation limit
  // ---------------------------------------------------------------
  localparam logic [SELECTED_ENDPOINT_NUMBER_W-1:0] RST_ENDPOINT_SELECT     = 3'h0;
  localparam logic [NUM_EP-1:0]  RST_ENDPOINT_FIFO_RESET = 7'h00;
  localparam logic [IRQ_W-1:0]   RST_IRQ                 = 8'h00;
  localparam logic [COUNT_W-1:0] RST_COUNT               = 11'h000;
  localparam logic [PTR_W-1:0]   RST_PTR                 = 10'h000;
  localparam logic [COUNT_W-1:0] COUNT_MAX               = 11'h7FF;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

endpackage

// ---- hw/usbec_irq_if.sv ----
// Interface carrying events, clears and mask writes to the interrupt collector
`timescale 1ns/10ps
interface usbec_irq_if;
  import usbec_pkg::*;
  logic [IRQ_W-1:0] evt;
  logic [IRQ_W-1:0] w1c;
  logic             mask_we;
  logic [IRQ_W-1:0] mask_wdata;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] mask;
  logic             irq;

  modport ctl (output evt, output w1c, output mask_we, output mask_wdata,
               input status, input mask, input irq);
  modport col (input evt, input w1c, input mask_we, input mask_wdata,
               output status, output mask, output irq);
endinterface

// ---- hw/usbec_irq.sv ----
// Sticky interrupt status with write-one-to-clear, mask and one level output
`timescale 1ns/10ps
module usbec_irq
  import usbec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  usbec_irq_if.col bus
);
  import usbec_pkg::*;

  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] status_d;
  logic [IRQ_W-1:0] mask_q;

  // Set wins over clear so an event landing on the clear write survives
  assign status_d = (status_q & ~bus.w1c) | bus.evt;

  // Status and mask storage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= RST_IRQ;
      mask_q   <= RST_IRQ;
    end
    else
    begin
      status_q <= status_d;
      if (bus.mask_we)
        mask_q <= bus.mask_wdata;
    end
  end

  assign bus.status = status_q;
  assign bus.mask   = mask_q;
  assign bus.irq    = |(status_q & mask_q);
endmodule

// ---- hw/usbec_ep_count.sv ----
// One endpoint: byte counter after the data PID, FIFO pointers and FIFO reset hold
`timescale 1ns/10ps
module usbec_ep_count
  import usbec_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               fifo_rst,
  input  wire logic               bus_rst,
  input  wire logic               pkt_start,
  input  wire logic               byte_valid,
  input  wire logic               pkt_end,
  input  wire logic               rd_byte,
  output logic                    accept,
  output logic                    pkt_done,
  output logic [COUNT_W-1:0]      last_count,
  output logic [PTR_W-1:0]        wr_ptr,
  output logic [PTR_W-1:0]        rd_ptr
);
  import usbec_pkg::*;

  logic [COUNT_W-1:0] run_q;
  logic [COUNT_W-1:0] last_q;
  logic [PTR_W-1:0]   wr_q;
  logic [PTR_W-1:0]   rd_q;
  logic               done_q;
  logic               take_byte;

  // No data enters while the FIFO reset bit is set
  assign accept    = ~fifo_rst;
  assign take_byte = byte_valid & accept & (run_q != COUNT_MAX);

  // Counting restarts at each data PID; the count latches at packet end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q  <= RST_COUNT;
      last_q <= RST_COUNT;
      wr_q   <= RST_PTR;
      rd_q   <= RST_PTR;
      done_q <= 1'b0;
    end
    else if (fifo_rst)
    begin
      run_q  <= RST_COUNT;
      last_q <= RST_COUNT;
      wr_q   <= RST_PTR;
      rd_q   <= RST_PTR;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= pkt_end & ~bus_rst;
      if (bus_rst)
      begin
        run_q  <= RST_COUNT;
        last_q <= RST_COUNT;
      end
      else if (pkt_start)
        run_q <= RST_COUNT;
      else if (take_byte)
        run_q <= run_q + 11'h001;
      if (pkt_end && !bus_rst)
        last_q <= run_q;
      if (take_byte)
        wr_q <= wr_q + 10'h001;
      if (rd_byte)
        rd_q <= rd_q + 10'h001;
    end
  end

  assign pkt_done   = done_q;
  assign last_count = last_q;
  assign wr_ptr     = wr_q;
  assign rd_ptr     = rd_q;
endmodule

// ---- tb/usbec_monitor.sv ----
// Assertion checker on the ports of the endpoint count block
`timescale 1ns/10ps
module usbec_monitor (
  input wire logic                         hclk,
  input wire logic                         hresetn,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  input wire logic [31:0]                  hrdata,
  input wire logic [usbec_pkg::NUM_EP-1:0] ep_src_pending,
  input wire logic [usbec_pkg::NUM_EP-1:0] ep_fifo_reset,
  input wire logic [usbec_pkg::NUM_EP-1:0] ep_accept
);
  import usbec_pkg::*;
  logic              rd_q;
  logic              wr_q;
  logic              wfr_q;
  logic [ADDR_W-1:0] a_q;
  logic [NUM_EP-1:0] wd_q;
  logic [NUM_EP-1:0] src_q;
  logic [3:0]        st_q;
  wire               done;
  assign done = rd_q && hready;
  // Slave view of the data phase; stability count keeps summary reads fair
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      wfr_q <= 1'b0;
      a_q   <= '0;
      wd_q  <= '0;
      src_q <= '0;
      st_q  <= 4'h0;
    end
    else
    begin
      if (hready)
      begin
        rd_q <= hsel && htrans[1] && !hwrite;
        wr_q <= hsel && htrans[1] && hwrite;
        a_q  <= haddr[ADDR_W-1:0];
      end
      wfr_q <= wr_q && hready && (a_q == ADDR_ENDPOINT_FIFO_RESET);
      wd_q  <= hwdata[NUM_EP-1:0];
      src_q <= ep_src_pending;
      st_q  <= (src_q != ep_src_pending) ? 4'h0 : st_q + {3'h0, st_q != 4'hF};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=>
    !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
  chk_accept_follows: assert property (ep_accept == ~ep_fifo_reset)
    else $error("accept not inverse of fifo reset");
  chk_low_width: assert property (done && a_q == ADDR_RX_COUNT_LOW |->
    hrdata[31:8] == 24'h0) else $error("count low upper bits set");
  chk_high_zero: assert property (done && a_q == ADDR_RX_COUNT_HIGH |->
    hrdata[31:3] == 29'h0) else $error("count high upper bits set");
  chk_reset_read: assert property (done && a_q == ADDR_ENDPOINT_FIFO_RESET |->
    hrdata == {25'h0, ep_fifo_reset}) else $error("fifo reset read wrong");
  chk_reset_write: assert property (wfr_q |-> ep_fifo_reset == wd_q)
    else $error("fifo reset write lost");
  chk_reset_only: assert property ($changed(ep_fifo_reset) |-> wfr_q)
    else $error("fifo reset bits moved without write");
  chk_summary_tracks: assert property (done && a_q == ADDR_ENDPOINT_IRQ_SUMMARY &&
    st_q > 4'h4 |-> hrdata == {25'h0, ep_src_pending}) else $error("summary wrong");
endmodule
bind usbec_top usbec_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ep_src_pending, .ep_fifo_reset,
  .ep_accept);

// ---- tb/usbec_host_model.sv ----
// Host traffic as delivered by the serial engine to the count logic
`timescale 1ns/10ps
module usbec_host_model (
  input  wire logic                          hclk,
  output logic [usbec_pkg::SELECTED_ENDPOINT_NUMBER_W-1:0]      rx_ep,
  output logic                               rx_pkt_start,
  output logic                               rx_byte_valid,
  output logic                               rx_pkt_end,
  output logic                               usb_bus_reset
);
  import usbec_pkg::*;
  // Quiet line at time zero
  initial
  begin
    rx_ep         = 3'h5;
    rx_pkt_start  = 1'b0;
    rx_byte_valid = 1'b0;
    rx_pkt_end    = 1'b0;
    usb_bus_reset = 1'b0;
  end
  // Data PID, n bytes, good end; slow leaves a gap after every byte
  task automatic send(input logic [SELECTED_ENDPOINT_NUMBER_W-1:0] ep, input int n, input bit slow);
    @(posedge hclk);
    rx_ep        <= ep;
    rx_pkt_start <= 1'b1;
    repeat (n)
    begin
      @(posedge hclk);
      rx_pkt_start  <= 1'b0;
      rx_byte_valid <= 1'b1;
      if (slow)
      begin
        @(posedge hclk);
        rx_byte_valid <= 1'b0;
      end
    end
    @(posedge hclk);
    rx_pkt_start  <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_pkt_end    <= 1'b1;
    @(posedge hclk);
    rx_pkt_end <= 1'b0;
    rx_ep      <= ~ep; // Idle endpoint lines carry nothing useful
  endtask
  // One cycle bus reset event
  task automatic bus_reset;
    @(posedge hclk);
    usb_bus_reset <= 1'b1;
    @(posedge hclk);
    usb_bus_reset <= 1'b0;
  endtask
endmodule

// ---- tb/test_usb_endpoint_count_and_fifo_reset.sv ----
// Self-checking bench of the endpoint count and FIFO reset registers
`timescale 1ns/10ps
module test_usb_endpoint_count_and_fifo_reset;
  import usbec_pkg::*;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic               hwrite;
  logic               hreadyout;
  logic               hresp;
  logic               fifo_rd;
  logic               irq;
  logic               m_rd;
  logic [31:0]        haddr;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic [1:0]         htrans;
  logic [SELECTED_ENDPOINT_NUMBER_W-1:0] rx_ep;
  logic               rx_pkt_start;
  logic               rx_byte_valid;
  logic               rx_pkt_end;
  logic               usb_bus_reset;
  logic [NUM_EP-1:0]  ep_src_pending;
  logic [NUM_EP-1:0]  ep_fifo_reset;
  logic [NUM_EP-1:0]  ep_accept;
  logic [NUM_EP-1:0]  src;
  logic [31:0]        exp_q[$];
  int                 lens[NUM_EP];
  int                 errors;
  int                 checks_done;
  wire                hready;
  assign hready = hreadyout;
  usbec_top DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .rx_ep, .rx_pkt_start, .rx_byte_valid, .rx_pkt_end,
    .usb_bus_reset, .fifo_rd, .ep_src_pending, .ep_fifo_reset, .ep_accept, .irq
  );
  usbec_host_model host (
    .hclk, .rx_ep, .rx_pkt_start, .rx_byte_valid, .rx_pkt_end, .usb_bus_reset
  );
  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Single transfer: address phase held until ready, then data phase until ready
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= 32'(a);
    do @(posedge hclk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Oldest expectation is judged when a read data phase completes
  initial
  begin
    m_rd = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (hready && m_rd)
        chk(hrdata, exp_q.pop_front(), "hrdata");
      if (hready)
        m_rd = hsel && htrans[1] && !hwrite;
    end
  end
  // Cut a hang short; about 40000 cycles
  initial
  begin
    #200000;
    errors++;
    complete_run;
  end
  initial
  begin
    hresetn        = 1'b0;
    hsel           = 1'b0;
    haddr          = 32'h0;
    htrans         = 2'h0;
    hwrite         = 1'b0;
    hwdata         = 32'h0;
    fifo_rd        = 1'b0;
    ep_src_pending = 7'h00;
    lens           = '{11'h000, 11'h0FF, 11'h100, 11'h3FF, 11'h7FF, 11'h001, 11'h001};
    void'($urandom(57354));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_ENDPOINT_FIFO_RESET, 32'h0);
    chk(32'(ep_accept), 32'h7F, "ep_accept");
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'h7F);
    rd(ADDR_ENDPOINT_FIFO_RESET, 32'h7F);
    chk(32'(ep_accept), 32'h0, "ep_accept");
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'h0);
    // Register updates on the edge that ends the write; look once it settles
    @(negedge hclk);
    chk(32'(ep_fifo_reset), 32'h0, "ep_fifo_reset");
    $display("test fifo reset done");
    for (int e = 0; e < NUM_EP; e++)
    begin
      if (e > 4)
        lens[e] = $urandom_range(600, 2);
      host.send(SELECTED_ENDPOINT_NUMBER_W'(e), lens[e], e[0]);
    end
    for (int e = 0; e < NUM_EP; e++)
    begin
      wr(ADDR_ENDPOINT_SELECT, 32'(e));
      rd(ADDR_RX_COUNT_LOW, 32'(lens[e]) & 32'hFF);
      rd(ADDR_RX_COUNT_HIGH, 32'(lens[e]) >> 8);
    end
    wr(ADDR_RX_COUNT_HIGH, 32'h0000_0001);
    wr(ADDR_ENDPOINT_IRQ_SUMMARY, 32'hFFFFFFFF);
    wr(12'h000, 32'hFF);
    wr(ADDR_ENDPOINT_SELECT, 32'h4);
    rd(ADDR_RX_COUNT_HIGH, 32'h7);
    rd(12'h000, 32'h0);
    rd(ADDR_ENDPOINT_IRQ_SUMMARY, 32'h0);
    $display("test counts done");
    host.send(3'h1, 300, 1'b0);
    host.send(3'h1, 5, 1'b1);
    wr(ADDR_ENDPOINT_SELECT, 32'h1);
    rd(ADDR_RX_COUNT_LOW, 32'h5);
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'h04);
    fifo_rd <= 1'(($urandom));
    host.send(3'h2, 10, 1'b0);
    fifo_rd <= 1'b0;
    wr(ADDR_ENDPOINT_SELECT, 32'h2);
    rd(ADDR_RX_COUNT_LOW, 32'h0);
    rd(ADDR_RX_COUNT_HIGH, 32'h0);
    chk(32'(ep_accept), 32'h7B, "ep_accept");
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'h0);
    $display("test restart and hold done");
    repeat (2)
    begin
      src = 7'($urandom);
      ep_src_pending <= src;
      repeat (6) @(posedge hclk);
      rd(ADDR_ENDPOINT_IRQ_SUMMARY, {25'h0, src});
    end
    $display("test summary done");
    wr(ADDR_IRQ_STATUS, 32'hFF);
    wr(ADDR_IRQ_MASK, 32'h08);
    rd(ADDR_IRQ_STATUS, 32'h0);
    host.send(3'h6, 3, 1'b0);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 32'h0, "irq");
    host.send(3'h3, 4, 1'b0);
    repeat (3) @(posedge hclk);
    chk(32'(irq), 32'h1, "irq");
    rd(ADDR_IRQ_STATUS, 32'h48);
    wr(ADDR_IRQ_STATUS, 32'h08);
    // Clear lands on the closing edge of the write; sample after it settles
    @(negedge hclk);
    chk(32'(irq), 32'h0, "irq");
    host.bus_reset;
    repeat (2) @(posedge hclk);
    rd(ADDR_IRQ_STATUS, 32'hC0);
    wr(ADDR_ENDPOINT_SELECT, 32'h4);
    rd(ADDR_RX_COUNT_HIGH, 32'h0);
    $display("test interrupts done");
    repeat (4) @(posedge hclk);
    complete_run;
  end
endmodule
